// File: include/dwm_pkg.sv
// Constants for the DDR4 write mask, inversion and preamble data-lane block
package dwm_pkg;
	// APB register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_LAT = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_LAST = 12'h00C;
	// Control register fields
	localparam int CTRL_MASK_EN = 0;
	localparam int CTRL_WINV_EN = 1;
	localparam int CTRL_RINV_EN = 2;
	localparam int CTRL_TERM_EN = 3;
	localparam int CTRL_CRC_EN = 4;
	localparam int CTRL_WPRE2 = 5;
	localparam int CTRL_RPRE2 = 6;
	localparam int CTRL_READOUT = 7;
	localparam int CTRL_TRAIN = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	// Latency register field width and reset
	localparam int LAT_W = 5;
	localparam logic [4:0] LAT_RESET = 5'h0B;
	// Status register fields
	localparam int STAT_CRC_ERR = 0;
	localparam int STAT_PERSIST = 1;
	localparam int STAT_TRAIN_DRV = 2;
	localparam int STAT_ILLEGAL = 3;
	localparam int STAT_RD_BUSY = 4;
	// Burst shape
	localparam int BEATS = 8;
	localparam int LANE_W = 8;
	// Timing: one device clock spans two sampling cycles of CLOCK
	localparam int CLK_PERIOD_PS = 8000;
	localparam int TCK_CYC = 2;
	localparam int TMOD_TCK = 24;
	localparam int SDO_EXTRA_PS = 9000;
	localparam int SDO_EXTRA_CYC = (SDO_EXTRA_PS / CLK_PERIOD_PS < 1) ? 1 :
		SDO_EXTRA_PS / CLK_PERIOD_PS;
	localparam int SDO_CYC = TMOD_TCK * TCK_CYC + SDO_EXTRA_CYC;
	localparam int RPRE1_CYC = 1 * TCK_CYC;
	localparam int RPRE2_CYC = 2 * TCK_CYC;
	localparam int RPST_CYC = TCK_CYC / 2;
	// Strobe edges seen before the first write beat in two-clock preamble
	localparam logic [1:0] WPRE2_SKIP = 2'h2;
	// Read engine states
	typedef enum logic [2:0] {
		RD_IDLE = 3'b000,
		RD_LAT = 3'b001,
		RD_PRE = 3'b010,
		RD_BURST = 3'b011,
		RD_POST = 3'b100
	} dwm_rd_state_t;
endpackage

// File: verilog/dwm_lane_top.sv
// Data-lane logic of a DDR4 x8 device: write mask, write inversion, preambles, training
// Operation
// [R1] Inversion flag low: invert lane before storing
// [R2] Inversion flag high: store lane data unchanged
// [R3] Eight beats per burst, one shared bit each
// [R4] Controller never enables masking and inversion together
// [R5] Only masking, termination, inversion or none legal
// [R6] Mask low with masking on: lane not written
// [R7] Mask high with masking on: lane written
// [R8] CRC plus masking: check first, discard on error
// [R9] CRC without masking: commit even on error
// [R10] Write preamble one or two clocks by bit
// [R11] Write and read preambles set independently
// [R12] Two-clock preamble only at supported data rates
// [R13] Two-clock write preamble raises primary write latency
// [R14] Two-clock mode: recovery and turnaround one higher
// [R15] Two-clock mode: column spacing even clock counts
// [R16] Write postamble fixed at half clock
// [R17] Read preamble one or two clocks by bit
// [R18] Training entered by bit, only in readout mode
// [R19] Strobes driven valid within driveout delay
// [R20] Training holds data lines high; a read burst during training still drives RD_DATA on them
// [R21] Strobes parked until readout read, then toggle
// [R22] Controller clears training bit to leave training
// [R23] Read postamble fixed at half clock
// [R24] Inversion on writes only, never on reads
// [R25] Shared bit sampled with its own beat
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module dwm_lane_top (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic WR_FRAME,
	input wire logic WR_STROBE,
	input wire logic [7:0] DQ_I,
	input wire logic WRITE_MASK_N_I,
	input wire logic CRC_ERR,
	output logic CORE_WE,
	output logic [63:0] CORE_DATA,
	output logic [7:0] CORE_BYTE_EN,
	input wire logic RD_CMD,
	input wire logic [63:0] RD_DATA,
	output logic [7:0] DQ_O,
	output logic DQ_OE_N,
	output logic STROBE_T_O,
	output logic STROBE_C_O,
	output logic STROBE_OE_N
);
	// Pin synchroniser: frame, strobe, shared bit and data travel together
	logic [10:0] pin_s1_q;
	logic [10:0] pin_s2_q;
	logic [10:0] pin_s3_q;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_q <= 11'h000;
			pin_s2_q <= 11'h000;
			pin_s3_q <= 11'h000;
		end else begin
			pin_s1_q <= {WR_FRAME, WR_STROBE, WRITE_MASK_N_I, DQ_I};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	wire frame = pin_s2_q[10];
	wire strobe_edge = pin_s2_q[9] ^ pin_s3_q[9];
	wire flag_n = pin_s2_q[8];
	wire [7:0] dq_in = pin_s2_q[7:0];

	// Registers
	logic [dwm_pkg::CTRL_W-1:0] ctrl_q;
	logic [dwm_pkg::LAT_W-1:0] lat_q;
	logic crc_err_q;
	logic [31:0] prdata_q;
	wire mask_en = ctrl_q[dwm_pkg::CTRL_MASK_EN];
	wire winv_en = ctrl_q[dwm_pkg::CTRL_WINV_EN];
	wire crc_en = ctrl_q[dwm_pkg::CTRL_CRC_EN];
	wire wpre2 = ctrl_q[dwm_pkg::CTRL_WPRE2];
	wire rpre2 = ctrl_q[dwm_pkg::CTRL_RPRE2];
	wire train = ctrl_q[dwm_pkg::CTRL_TRAIN];
	wire persist = crc_en & mask_en;
	wire illegal = mask_en & winv_en;

	wire apb_setup = PSEL & ~PENABLE;
	wire apb_access = PSEL & PENABLE;
	wire hit_ctrl = PADDR == dwm_pkg::ADDR_CTRL;
	wire hit_lat = PADDR == dwm_pkg::ADDR_LAT;
	wire hit_status = PADDR == dwm_pkg::ADDR_STATUS;
	wire hit_last = PADDR == dwm_pkg::ADDR_LAST;
	wire hit_any = hit_ctrl | hit_lat | hit_status | hit_last;
	wire wr_ctrl = apb_access & PWRITE & hit_ctrl;
	wire wr_lat = apb_access & PWRITE & hit_lat;
	wire wr_status = apb_access & PWRITE & hit_status;
	assign PREADY = apb_access;
	assign PSLVERR = apb_access & ~hit_any;
	assign PRDATA = prdata_q;

	// Training is accepted only when readout mode is on in the same value
	wire [dwm_pkg::CTRL_W-1:0] ctrl_wr_val = {
		PWDATA[dwm_pkg::CTRL_TRAIN] & PWDATA[dwm_pkg::CTRL_READOUT],
		PWDATA[dwm_pkg::CTRL_W-2:0]}; // [R18] [R22]

	// Write path
	logic [1:0] skip_q;
	logic [2:0] beat_q;
	logic [63:0] wbuf_q;
	logic [7:0] wen_q;
	logic burst_done_q;
	logic core_we_q;
	logic [63:0] core_data_q;
	logic [7:0] core_be_q;
	logic [7:0] last_be_q;
	logic last_commit_q;

	wire beat_take = frame & strobe_edge & (skip_q == 2'h0);
	// Masking has priority if software sets both functions
	wire lane_en = mask_en ? flag_n : 1'b1; // [R6] [R7]
	wire lane_inv = ~mask_en & winv_en & ~flag_n; // [R1] [R2]
	wire [7:0] lane_byte = lane_inv ? ~dq_in : dq_in; // [R1] [R2]
	wire last_beat = beat_q == 3'(dwm_pkg::BEATS - 1); // [R3]
	// Persistent mode drops the burst on a CRC error
	wire commit = ~(persist & CRC_ERR); // [R8] [R9]
	wire crc_set = burst_done_q & crc_en & CRC_ERR;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			skip_q <= 2'h0;
			beat_q <= 3'h0;
			wbuf_q <= 64'h0000000000000000;
			wen_q <= 8'h00;
			burst_done_q <= 1'b0;
		end else begin
			burst_done_q <= beat_take & last_beat;
			if (!frame) begin
				// Edges of a two-clock preamble carry no data
				skip_q <= wpre2 ? dwm_pkg::WPRE2_SKIP : 2'h0; // [R10] [R11]
				// Frame drop after the half-clock postamble closes the burst
				beat_q <= 3'h0; // [R16]
			end else if (strobe_edge && skip_q != 2'h0) begin
				skip_q <= skip_q - 2'h1; // [R10]
			end else if (beat_take) begin
				// Data and shared bit come from the same edge
				wbuf_q[beat_q*8 +: 8] <= lane_byte; // [R25] [R3]
				wen_q[beat_q] <= lane_en; // [R25]
				beat_q <= beat_q + 3'h1;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			core_we_q <= 1'b0;
			core_data_q <= 64'h0000000000000000;
			core_be_q <= 8'h00;
			last_be_q <= 8'h00;
			last_commit_q <= 1'b0;
		end else begin
			core_we_q <= burst_done_q & commit; // [R8] [R9]
			if (burst_done_q) begin
				core_data_q <= wbuf_q;
				core_be_q <= wen_q;
				last_be_q <= wen_q;
				last_commit_q <= commit;
			end
		end
	end
	assign CORE_WE = core_we_q;
	assign CORE_DATA = core_data_q;
	assign CORE_BYTE_EN = core_be_q;

	// Register file
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= dwm_pkg::CTRL_RESET;
			lat_q <= dwm_pkg::LAT_RESET;
			crc_err_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_wr_val;
			end
			if (wr_lat) begin
				lat_q <= PWDATA[dwm_pkg::LAT_W-1:0];
			end
			// A new error in the clearing cycle is kept
			if (crc_set) begin
				crc_err_q <= 1'b1;
			end else if (wr_status && PWDATA[dwm_pkg::STAT_CRC_ERR]) begin
				crc_err_q <= 1'b0;
			end
		end
	end

	// Read engine
	dwm_pkg::dwm_rd_state_t rd_q;
	dwm_pkg::dwm_rd_state_t rd_d;
	logic [5:0] rcnt_q;
	logic [5:0] rcnt_d;
	logic [10:0] sdo_q;
	logic train_drv_q;
	logic [7:0] dq_o_q;
	logic dq_oe_n_q;
	logic stb_t_q;
	logic stb_c_q;
	logic stb_oe_n_q;

	wire [5:0] lat_cyc = 6'({lat_q, 1'b0}); // Device clocks to sampling cycles
	wire [5:0] pre_cyc = rpre2 ? 6'(dwm_pkg::RPRE2_CYC) : 6'(dwm_pkg::RPRE1_CYC); // [R17] [R11]
	wire rcnt_end = rcnt_q == 6'h00;

	always_comb begin
		rd_d = rd_q;
		rcnt_d = rcnt_end ? 6'h00 : rcnt_q - 6'h01;
		unique case (rd_q)
			dwm_pkg::RD_IDLE: begin
				if (RD_CMD) begin
					rd_d = dwm_pkg::RD_LAT; // [R21]
					rcnt_d = (lat_cyc == 6'h00) ? 6'h00 : lat_cyc - 6'h01;
				end
			end
			dwm_pkg::RD_LAT: begin
				if (rcnt_end) begin
					rd_d = dwm_pkg::RD_PRE;
					rcnt_d = pre_cyc - 6'h01;
				end
			end
			dwm_pkg::RD_PRE: begin
				if (rcnt_end) begin
					rd_d = dwm_pkg::RD_BURST;
					rcnt_d = 6'(dwm_pkg::BEATS - 1);
				end
			end
			dwm_pkg::RD_BURST: begin
				if (rcnt_end) begin
					rd_d = dwm_pkg::RD_POST;
					rcnt_d = 6'(dwm_pkg::RPST_CYC - 1); // [R23]
				end
			end
			dwm_pkg::RD_POST: begin
				if (rcnt_end) begin
					rd_d = dwm_pkg::RD_IDLE;
				end
			end
			default: begin
				rd_d = dwm_pkg::RD_IDLE;
				rcnt_d = 6'h00;
			end
		endcase
	end

	// Two-clock preamble shows one high pulse before the last low clock
	wire in_pre = rd_q == dwm_pkg::RD_PRE;
	wire pre_high = rpre2 && in_pre && (rcnt_q == 6'(dwm_pkg::RPRE1_CYC)); // [R17]
	wire [2:0] rbeat = 3'(dwm_pkg::BEATS - 1) - rcnt_q[2:0];
	wire in_burst = rd_q == dwm_pkg::RD_BURST;
	wire rd_active = rd_q != dwm_pkg::RD_IDLE;
	wire rd_latency = rd_q == dwm_pkg::RD_LAT;
	// Outside training, strobes stay released during latency so the preamble is exactly one or two clocks
	wire drive_stb = (rd_active & ~rd_latency) | train_drv_q; // [R17]

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rd_q <= dwm_pkg::RD_IDLE;
			rcnt_q <= 6'h00;
			sdo_q <= 11'h000;
			train_drv_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			rcnt_q <= rcnt_d;
			if (!train) begin
				sdo_q <= 11'(dwm_pkg::SDO_CYC - 1);
				train_drv_q <= 1'b0;
			end else if (sdo_q != 11'h000) begin
				sdo_q <= sdo_q - 11'h001; // [R19]
			end else begin
				train_drv_q <= 1'b1; // [R19]
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			dq_o_q <= 8'hFF;
			dq_oe_n_q <= 1'b1;
			stb_t_q <= 1'b0;
			stb_c_q <= 1'b1;
			stb_oe_n_q <= 1'b1;
		end else begin
			// Read data leaves as stored, with no inversion
			dq_o_q <= in_burst ? RD_DATA[rbeat*8 +: 8] : 8'hFF; // [R24] [R20]
			dq_oe_n_q <= ~(in_burst | train_drv_q); // [R20]
			stb_t_q <= in_burst ? ~rbeat[0] : pre_high; // [R21] [R23]
			stb_c_q <= in_burst ? rbeat[0] : ~pre_high; // [R21]
			stb_oe_n_q <= ~drive_stb; // [R19] [R21]
		end
	end
	assign DQ_O = dq_o_q;
	assign DQ_OE_N = dq_oe_n_q;
	assign STROBE_T_O = stb_t_q;
	assign STROBE_C_O = stb_c_q;
	assign STROBE_OE_N = stb_oe_n_q;

	// Read data is captured in the setup cycle and returned in the access cycle
	wire [31:0] status_word = {27'h0000000, rd_active, illegal, train_drv_q, persist, crc_err_q};
	wire [31:0] last_word = {23'h000000, last_commit_q, last_be_q};
	wire [31:0] rd_mux = hit_ctrl ? {23'h000000, ctrl_q} :
		hit_lat ? {27'h0000000, lat_q} :
		hit_status ? status_word :
		hit_last ? last_word : 32'h00000000;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			prdata_q <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_q <= rd_mux;
		end
	end
endmodule

// File: tb/dwm_lane_assertions.sv
// Concurrent checks on the lane block's ports
`timescale 1ns/1ps
module dwm_lane_chk (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [31:0] PRDATA,
	input wire logic WR_FRAME,
	input wire logic CORE_WE,
	input wire logic [63:0] CORE_DATA,
	input wire logic [7:0] DQ_O,
	input wire logic DQ_OE_N,
	input wire logic STROBE_T_O,
	input wire logic STROBE_C_O,
	input wire logic STROBE_OE_N
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	sequence beats8;
		!DQ_OE_N [*8];
	endsequence
	sequence frame_idle;
		!WR_FRAME [*8];
	endsequence
	err_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error response malformed");
	we_pulse_a: assert property (CORE_WE |=> !CORE_WE)
		else $error("commit pulse too long");
	we_hold_a: assert property (CORE_WE |=> $stable(CORE_DATA) [*4])
		else $error("committed data moved");
	frame_gap_a: assert property (frame_idle |=> !CORE_WE)
		else $error("commit without a frame");
	dq_idle_a: assert property (DQ_OE_N |-> DQ_O == 8'hFF)
		else $error("data lines not high when idle");
	strobe_pair_a: assert property (!STROBE_OE_N |-> STROBE_C_O != STROBE_T_O)
		else $error("strobe pair not complementary");
	dq_strobe_a: assert property (!DQ_OE_N |-> !STROBE_OE_N)
		else $error("data driven without strobes");
	burst_len_a: assert property ($fell(DQ_OE_N) |-> beats8)
		else $error("read burst shorter than eight beats");
	post_low_a: assert property ($rose(DQ_OE_N) |-> !STROBE_T_O)
		else $error("postamble strobe not low");
endmodule

// File: tb/dwm_wr_ctrl.sv
// Memory controller model driving the write link
`timescale 1ns/1ps
module dwm_wr_ctrl (
	output logic frame,
	output logic strobe,
	output logic [7:0] dq,
	output logic mask_n
);
	initial begin
		frame = 1'h0;
		strobe = 1'h0;
		dq = 8'h00;
		mask_n = 1'h1;
	end
	task automatic burst(input logic [63:0] d, input logic [7:0] m, input logic pre2);
		// Step off the clock edge on which the call starts
		#0.5;
		frame = 1'h1;
		#62;
		if (pre2) begin
			repeat (2) begin
				strobe = ~strobe;
				#62.5;
			end
		end
		for (int k = 0; k < 8; k++) begin
			dq = d[8*k+:8];
			mask_n = m[k];
			#31.25;
			strobe = ~strobe;
			#31.25;
		end
		// Half-clock postamble, then released lines show a changed level
		#62.5;
		dq = ~dq;
		mask_n = ~mask_n;
		frame = 1'h0;
		// Gap of an even clock count, long enough for recovery
		#250;
	endtask
endmodule

// File: tb/dwm_lane_tb_top.sv
// Self-checking bench for the data-lane block
`timescale 1ns/1ps
module dwm_lane_tb_top;
	logic CLOCK, RST_B, PSEL, PENABLE, PWRITE, RD_CMD, CRC_ERR, er;
	logic PREADY, PSLVERR, CORE_WE, DQ_OE_N, STROBE_T_O, STROBE_C_O, STROBE_OE_N;
	logic WR_FRAME, WR_STROBE, WRITE_MASK_N_I;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [7:0] DQ_I, DQ_O, CORE_BYTE_EN, m;
	logic [63:0] RD_DATA, CORE_DATA, d;
	logic [8:0] modes [8] = '{9'h001, 9'h002, 9'h000, 9'h008,
		9'h011, 9'h010, 9'h021, 9'h022};
	logic [8:0] rmodes [3] = '{9'h002, 9'h040, 9'h020};
	int failures = 0, samples_checked = 0, we_cnt = 0, w0, pre, post, nb, th;
	dwm_lane_top dut (
		.CLOCK(CLOCK),
		.RST_B(RST_B),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.WR_FRAME(WR_FRAME),
		.WR_STROBE(WR_STROBE),
		.DQ_I(DQ_I),
		.WRITE_MASK_N_I(WRITE_MASK_N_I),
		.CRC_ERR(CRC_ERR),
		.CORE_WE(CORE_WE),
		.CORE_DATA(CORE_DATA),
		.CORE_BYTE_EN(CORE_BYTE_EN),
		.RD_CMD(RD_CMD),
		.RD_DATA(RD_DATA),
		.DQ_O(DQ_O),
		.DQ_OE_N(DQ_OE_N),
		.STROBE_T_O(STROBE_T_O),
		.STROBE_C_O(STROBE_C_O),
		.STROBE_OE_N(STROBE_OE_N)
	);
	dwm_wr_ctrl ctl (.frame(WR_FRAME), .strobe(WR_STROBE), .dq(DQ_I), .mask_n(WRITE_MASK_N_I));
	initial begin
		CLOCK = 1'h0;
		forever #4 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) if (CORE_WE === 1'h1) we_cnt++;
	function logic [63:0] inv_of(input logic [8:0] c, input logic [7:0] mk);
		for (int k = 0; k < 8; k++) inv_of[8*k+:8] = {8{c[1] && !c[0] && !mk[k]}};
	endfunction
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge CLOCK);
		PSEL <= 1'h1;
		PENABLE <= 1'h0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		do @(posedge CLOCK); while (PREADY !== 1'h1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	task wr_burst(input logic [8:0] c, input logic err);
		apb(1'h1, dwm_pkg::ADDR_CTRL, {23'h0, c});
		d = {$urandom, $urandom};
		m = 8'($urandom);
		w0 = we_cnt;
		CRC_ERR <= err;
		ctl.burst(d, m, c[dwm_pkg::CTRL_WPRE2]);
		@(posedge CLOCK);
		CRC_ERR <= 1'h0;
		chk("byte_en", 64'(c[0] ? m : 8'hFF), 64'(CORE_BYTE_EN));
		chk("core_data", d ^ inv_of(c, m), CORE_DATA);
		chk("commit", 64'(!(err && c[4] && c[0])), 64'(we_cnt - w0));
		apb(1'h0, dwm_pkg::ADDR_STATUS, 32'h0);
		chk("crc_flag", 64'(err && c[4]), 64'(rd[dwm_pkg::STAT_CRC_ERR]));
		chk("persist", 64'(c[4] && c[0]), 64'(rd[dwm_pkg::STAT_PERSIST]));
		apb(1'h1, dwm_pkg::ADDR_STATUS, 32'h1);
	endtask
	task rd_burst(input logic [8:0] c);
		RD_DATA <= {$urandom, $urandom};
		RD_CMD <= 1'h1;
		@(posedge CLOCK);
		RD_CMD <= 1'h0;
		pre = 0;
		post = 0;
		nb = 0;
		th = 0;
		repeat (40) begin
			@(negedge CLOCK);
			th += int'(STROBE_T_O);
			if (STROBE_OE_N === 1'h0 && DQ_OE_N === 1'h0 && !c[8]) begin
				chk("beat", 64'(RD_DATA[8*nb+:8]), 64'(DQ_O));
				nb++;
			end else if (STROBE_OE_N === 1'h0) begin
				if (nb == 0) pre++;
				else post++;
			end
		end
		if (!c[8]) begin
			chk("preamble", c[6] ? 64'h4 : 64'h2, 64'(pre));
			chk("beats", 64'h8, 64'(nb));
			chk("postamble", 64'h1, 64'(post));
		end
	endtask
	task end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		end_sim;
	end
	initial begin
		{RST_B, PSEL, PENABLE, PWRITE, RD_CMD, CRC_ERR} = 6'h00;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		RD_DATA = 64'h0;
		void'($urandom(32'hE8DA));
		repeat (12) @(posedge CLOCK);
		RST_B <= 1'h1;
		apb(1'h0, dwm_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl_rst", 64'(dwm_pkg::CTRL_RESET), 64'(rd));
		apb(1'h0, dwm_pkg::ADDR_LAT, 32'h0);
		chk("lat_rst", 64'(dwm_pkg::LAT_RESET), 64'(rd));
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", 64'h1, 64'(er));
		apb(1'h1, dwm_pkg::ADDR_CTRL, 32'h100);
		apb(1'h0, dwm_pkg::ADDR_CTRL, 32'h0);
		chk("train_refused", 64'h0, 64'(rd));
		$display("registers done");
		for (int i = 0; i < 16; i++) wr_burst(modes[i%8], i < 8 ? modes[i][4] : 1'($urandom));
		$display("writes done");
		apb(1'h1, dwm_pkg::ADDR_LAT, 32'h0);
		foreach (rmodes[i]) begin
			apb(1'h1, dwm_pkg::ADDR_CTRL, {23'h0, rmodes[i]});
			rd_burst(rmodes[i]);
		end
		$display("reads done");
		apb(1'h1, dwm_pkg::ADDR_CTRL, 32'h080);
		apb(1'h1, dwm_pkg::ADDR_CTRL, 32'h180);
		repeat (dwm_pkg::SDO_CYC + 3) @(posedge CLOCK);
		@(negedge CLOCK);
		chk("train_oe", 64'h0, 64'(STROBE_OE_N));
		chk("train_park", 64'h1, 64'({STROBE_T_O, STROBE_C_O}));
		chk("train_dq", 64'h0FF, 64'({DQ_OE_N, DQ_O}));
		rd_burst(9'h180);
		chk("train_toggle", 64'h4, 64'(th));
		apb(1'h1, dwm_pkg::ADDR_CTRL, 32'h080);
		repeat (4) @(posedge CLOCK);
		chk("train_exit", 64'h1, 64'(STROBE_OE_N));
		$display("training done");
		end_sim;
	end
endmodule
bind dwm_lane_top dwm_lane_chk chk (
	.CLOCK(CLOCK),
	.RST_B(RST_B),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.PRDATA(PRDATA),
	.WR_FRAME(WR_FRAME),
	.CORE_WE(CORE_WE),
	.CORE_DATA(CORE_DATA),
	.DQ_O(DQ_O),
	.DQ_OE_N(DQ_OE_N),
	.STROBE_T_O(STROBE_T_O),
	.STROBE_C_O(STROBE_C_O),
	.STROBE_OE_N(STROBE_OE_N)
);
